// ==== lsbf_pkg.sv ====
// Constants, register map and state encoding for the LED sink blink and fade control
// Function
// - Fade law 00 selects the linear DAC with linear steps and 01 the square DAC with linear steps.
// - Fade law 10 and 11 select the square DAC with cubic time-step profiles A and B.
// - Both cubic laws keep the square-law DAC codes and only change the dwell time per code.
// - Enable bits 0 to 6 switch sinks 1 to 7 on (1) or off (0); bit 7 is reserved.
// - On-time bits 7:6 select 0.2 s, 0.6 s, 0.8 s or 1.2 s for every blinking sink.
// - An enabled sink with a nonzero off-time stays lit for the on-time and then goes off.
// - Off-times of sinks 7, 6 and 5 sit in bits 5:4, 3:2 and 1:0 of timing register A.
// - Off-time 00 disables the off phase, 01 is 0.6 s, 10 is 1.2 s and 11 is 1.8 s.
// - A blinking sink alternates off-time and on-time for as long as it stays enabled.
// - An enabled sink whose off-time is 00 stays lit without blinking.
// - Off-times of sinks 4, 3, 2 and 1 sit in bits 7:6, 5:4, 3:2 and 1:0 of timing register B.
package lsbf_pkg;

  localparam logic [7:0] FADE_LAW_OFFSET    = 8'h0F;
  localparam logic [7:0] ENABLE_OFFSET      = 8'h10;
  localparam logic [7:0] BLINK_TIME_A_OFFSET = 8'h11;
  localparam logic [7:0] BLINK_TIME_B_OFFSET = 8'h12;

  localparam logic [1:0] FADE_LAW_RESET     = 2'h0;
  localparam logic [6:0] ENABLE_RESET       = 7'h00;
  localparam logic [7:0] BLINK_TIME_A_RESET = 8'h00;
  localparam logic [7:0] BLINK_TIME_B_RESET = 8'h00;

  localparam int FADE_LAW_LSB  = 0;
  localparam int ON_TIME_LSB   = 6;
  localparam int NUM_SINKS     = 7;

  localparam logic [1:0] LAW_LINEAR   = 2'h0;
  localparam logic [1:0] LAW_SQUARE   = 2'h1;
  localparam logic [1:0] LAW_CUBIC_A  = 2'h2;
  localparam logic [1:0] LAW_CUBIC_B  = 2'h3;

  localparam logic [1:0] STEP_LINEAR  = 2'h0;
  localparam logic [1:0] STEP_CUBIC_A = 2'h1;
  localparam logic [1:0] STEP_CUBIC_B = 2'h2;

  // Every documented on and off time is a whole multiple of this step
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TIME_STEP_MS = 200;
  localparam int unsigned STEP_CYCLES  = CLK_HZ / 1000 * TIME_STEP_MS;

  localparam logic [3:0] ON_STEPS_00  = 4'h1;
  localparam logic [3:0] ON_STEPS_01  = 4'h3;
  localparam logic [3:0] ON_STEPS_10  = 4'h4;
  localparam logic [3:0] ON_STEPS_11  = 4'h6;
  localparam logic [3:0] OFF_STEPS_01 = 4'h3;
  localparam logic [3:0] OFF_STEPS_10 = 4'h6;
  localparam logic [3:0] OFF_STEPS_11 = 4'h9;

  typedef enum logic [2:0] {
    BLINK_IDLE = 3'b001,
    BLINK_ON   = 3'b010,
    BLINK_OFF  = 3'b100
  } lsbf_blink_state_e;

endpackage : lsbf_pkg

// ==== lsbf_sink_blink.sv ====
// One sink's on/off blink sequencer
`timescale 1ns/1ps
`default_nettype none
module lsbf_sink_blink #(
  parameter int unsigned STEP_CYCLES = lsbf_pkg::STEP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [1:0] on_sel,
  input  wire logic [1:0] off_sel,
  output logic            lit
);

  lsbf_pkg::lsbf_blink_state_e state;
  logic [31:0]                 count;
  logic [3:0]                  on_steps;
  logic [3:0]                  off_steps;
  logic [31:0]                 on_cycles;
  logic [31:0]                 off_cycles;

  always_comb begin
    case (on_sel)
      2'h0:    on_steps = lsbf_pkg::ON_STEPS_00;
      2'h1:    on_steps = lsbf_pkg::ON_STEPS_01;
      2'h2:    on_steps = lsbf_pkg::ON_STEPS_10;
      default: on_steps = lsbf_pkg::ON_STEPS_11;
    endcase
    case (off_sel)
      2'h1:    off_steps = lsbf_pkg::OFF_STEPS_01;
      2'h2:    off_steps = lsbf_pkg::OFF_STEPS_10;
      default: off_steps = lsbf_pkg::OFF_STEPS_11;
    endcase
    on_cycles  = 32'(32'(on_steps) * STEP_CYCLES);
    off_cycles = 32'(32'(off_steps) * STEP_CYCLES);
  end

  // Comparing with >= lets a shortened time end the phase at once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= lsbf_pkg::BLINK_IDLE;
      lit   <= 1'b0;
      count <= 32'h0;
    end else begin
      case (state)
        lsbf_pkg::BLINK_IDLE: begin
          if (enable) begin
            state <= lsbf_pkg::BLINK_ON;
            lit   <= 1'b1;
          end
          count <= 32'h0;
        end
        lsbf_pkg::BLINK_ON: begin
          if (!enable) begin
            state <= lsbf_pkg::BLINK_IDLE;
            lit   <= 1'b0;
            count <= 32'h0;
          end else if (off_sel == 2'h0) begin
            count <= 32'h0;
          end else if (count >= on_cycles - 32'h1) begin
            state <= lsbf_pkg::BLINK_OFF;
            lit   <= 1'b0;
            count <= 32'h0;
          end else begin
            count <= count + 32'h1;
          end
        end
        lsbf_pkg::BLINK_OFF: begin
          if (!enable) begin
            state <= lsbf_pkg::BLINK_IDLE;
            count <= 32'h0;
          end else if (off_sel == 2'h0 || count >= off_cycles - 32'h1) begin
            state <= lsbf_pkg::BLINK_ON;
            lit   <= 1'b1;
            count <= 32'h0;
          end else begin
            count <= count + 32'h1;
          end
        end
        default: begin
          state <= lsbf_pkg::BLINK_IDLE;
          lit   <= 1'b0;
          count <= 32'h0;
        end
      endcase
    end
  end

  disabled_goes_dark_a: assert property (@(posedge clk_sys) disable iff (reset)
    !enable |=> !lit) else $error("disabled sink still lit");

  steady_on_a: assert property (@(posedge clk_sys) disable iff (reset)
    enable && off_sel == 2'h0 |=> lit) else $error("sink with off phase disabled not lit");

  on_phase_length_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(lit) && $past(enable) |-> $past(count) >= $past(on_cycles) - 32'h1)
    else $error("on phase ended early");

  off_phase_length_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(lit) && $past(state) == lsbf_pkg::BLINK_OFF && $past(off_sel) != 2'h0
    |-> $past(count) >= $past(off_cycles) - 32'h1)
    else $error("off phase ended early");

endmodule : lsbf_sink_blink
`default_nettype wire

// ==== lsbf_ctrl.sv ====
// Register file, fade law decode and seven blink sequencers for the LED current sinks
`timescale 1ns/1ps
`default_nettype none
module lsbf_ctrl #(
  parameter int unsigned STEP_CYCLES = lsbf_pkg::STEP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic      [6:0] sink_on,
  output logic            dac_square_law,
  output logic      [1:0] time_step_profile
);

  logic [1:0]  fade_transfer_law;
  logic [6:0]  sink_enable;
  logic [7:0]  sink_blink_time_a;
  logic [7:0]  sink_blink_time_b;
  logic [1:0]  blink_on_time;
  logic [13:0] off_fields;

  // Only implemented bits are stored, so reserved bits cannot reach the sinks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fade_transfer_law <= lsbf_pkg::FADE_LAW_RESET;
    end else if (reg_write && reg_addr == lsbf_pkg::FADE_LAW_OFFSET) begin
      fade_transfer_law <= reg_wdata[lsbf_pkg::FADE_LAW_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sink_enable <= lsbf_pkg::ENABLE_RESET;
    end else if (reg_write && reg_addr == lsbf_pkg::ENABLE_OFFSET) begin
      sink_enable <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sink_blink_time_a <= lsbf_pkg::BLINK_TIME_A_RESET;
    end else if (reg_write && reg_addr == lsbf_pkg::BLINK_TIME_A_OFFSET) begin
      sink_blink_time_a <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sink_blink_time_b <= lsbf_pkg::BLINK_TIME_B_RESET;
    end else if (reg_write && reg_addr == lsbf_pkg::BLINK_TIME_B_OFFSET) begin
      sink_blink_time_b <= reg_wdata;
    end
  end

  // Read data is registered; unmapped addresses answer zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        lsbf_pkg::FADE_LAW_OFFSET:     reg_rdata <= {6'h00, fade_transfer_law};
        lsbf_pkg::ENABLE_OFFSET:       reg_rdata <= {1'b0, sink_enable};
        lsbf_pkg::BLINK_TIME_A_OFFSET: reg_rdata <= sink_blink_time_a;
        lsbf_pkg::BLINK_TIME_B_OFFSET: reg_rdata <= sink_blink_time_b;
        default:                       reg_rdata <= 8'h00;
      endcase
    end
  end

  // Law decode; the DAC code path is untouched by the cubic laws
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dac_square_law    <= 1'b0;
      time_step_profile <= lsbf_pkg::STEP_LINEAR;
    end else begin
      case (fade_transfer_law)
        lsbf_pkg::LAW_LINEAR: begin
          dac_square_law    <= 1'b0;
          time_step_profile <= lsbf_pkg::STEP_LINEAR;
        end
        lsbf_pkg::LAW_SQUARE: begin
          dac_square_law    <= 1'b1;
          time_step_profile <= lsbf_pkg::STEP_LINEAR;
        end
        lsbf_pkg::LAW_CUBIC_A: begin
          dac_square_law    <= 1'b1;
          time_step_profile <= lsbf_pkg::STEP_CUBIC_A;
        end
        default: begin
          dac_square_law    <= 1'b1;
          time_step_profile <= lsbf_pkg::STEP_CUBIC_B;
        end
      endcase
    end
  end

  assign blink_on_time = sink_blink_time_a[lsbf_pkg::ON_TIME_LSB +: 2];
  // Field of sink n+1 is off_fields[2n+1:2n]
  assign off_fields    = {sink_blink_time_a[5:0], sink_blink_time_b};

  for (genvar i = 0; i < lsbf_pkg::NUM_SINKS; i++) begin : g_sink
    lsbf_sink_blink #(
      .STEP_CYCLES (STEP_CYCLES)
    ) u_blink (
      .clk_sys (clk_sys),
      .reset   (reset),
      .enable  (sink_enable[i]),
      .on_sel  (blink_on_time),
      .off_sel (off_fields[2*i +: 2]),
      .lit     (sink_on[i])
    );
  end

  law_linear_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 dac_square_law == ($past(fade_transfer_law) != lsbf_pkg::LAW_LINEAR))
    else $error("square law select does not follow fade law");

  law_cubic_profile_a: assert property (@(posedge clk_sys) disable iff (reset)
    fade_transfer_law == lsbf_pkg::LAW_CUBIC_B |=> time_step_profile == lsbf_pkg::STEP_CUBIC_B && dac_square_law)
    else $error("cubic B law decoded wrongly");

  law_reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_read && reg_addr == lsbf_pkg::FADE_LAW_OFFSET |=> reg_rdata == {6'h00, $past(fade_transfer_law)})
    else $error("reserved law bits read nonzero");

  enable_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_write && reg_addr == lsbf_pkg::ENABLE_OFFSET |=> sink_enable == $past(reg_wdata[6:0]) ##1
    sink_on == ($past(reg_wdata[6:0], 2) & sink_on))
    else $error("enable write not applied");

  timing_b_store_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_write && reg_addr == lsbf_pkg::BLINK_TIME_B_OFFSET && !reg_read
    ##1 reg_read && reg_addr == lsbf_pkg::BLINK_TIME_B_OFFSET && !reg_write
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("timing register B readback wrong");

endmodule : lsbf_ctrl
`default_nettype wire

// ==== lsbf_sink_model.sv ====
// Behavioural sink load that measures the lit and dark run length of each sink
`timescale 1ns/1ps
`default_nettype none
module lsbf_sink_model (
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic [6:0]      sink_on,
  output logic      [6:0][7:0] on_len,
  output logic      [6:0][7:0] off_len
);
  logic [6:0][7:0] run;
  logic [6:0]      last;

  // A run is latched only when it ends, so a steady sink keeps its old lengths
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run <= '0;
      last <= '0;
      on_len <= '0;
      off_len <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (sink_on[i] != last[i]) begin
          run[i] <= 8'h01;
          if (last[i]) on_len[i] <= run[i];
          else off_len[i] <= run[i];
        end else if (run[i] != 8'hFF) begin
          run[i] <= run[i] + 8'h01;
        end
      end
      last <= sink_on;
    end
  end
endmodule : lsbf_sink_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the LED sink blink and fade control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned STEP = 4;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_write = 1'b0;
  logic            reg_read = 1'b0;
  logic [7:0]      reg_rdata;
  logic [6:0]      sink_on;
  logic            dac_square_law;
  logic [1:0]      time_step_profile;
  logic [6:0][7:0] on_len;
  logic [6:0][7:0] off_len;
  int              n_fail = 0;
  int              checks = 0;
  int              cycles = 0;
  logic [7:0]      ta;
  logic [7:0]      tb;

  always #2.5 clk_sys = ~clk_sys;

  lsbf_ctrl #(.STEP_CYCLES(STEP)) uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sink_on(sink_on), .dac_square_law(dac_square_law), .time_step_profile(time_step_profile));
  lsbf_sink_model load (.clk_sys(clk_sys), .reset(reset), .sink_on(sink_on), .on_len(on_len),
    .off_len(off_len));

  function automatic logic [7:0] on_cyc(input logic [1:0] s);
    return (s == 2'h0) ? 8'(STEP) : (s == 2'h1) ? 8'(3 * STEP) : (s == 2'h2) ? 8'(4 * STEP) : 8'(6 * STEP);
  endfunction : on_cyc

  function automatic logic [7:0] off_cyc(input logic [1:0] s);
    return 8'(3 * STEP * int'(s));
  endfunction : off_cyc

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    #1;
    check($sformatf("rdata@%h", a), exp, reg_rdata);
  endtask : rd

  task automatic trial(input logic [7:0] a, input logic [7:0] b);
    logic [13:0] f;
    f = {a[5:0], b};
    wr(8'h10, 8'h00);
    wr(8'h11, a);
    wr(8'h12, b);
    rd(8'h11, a);
    rd(8'h12, b);
    wr(8'h10, 8'h7F);
    repeat (200) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 7; i++) begin
      if (f[2*i +: 2] == 2'h0) check($sformatf("steady sink %0d", i), 8'h01, {7'h00, sink_on[i]});
      else begin
        check($sformatf("on run sink %0d", i), on_cyc(a[7:6]), on_len[i]);
        check($sformatf("off run sink %0d", i), off_cyc(f[2*i +: 2]), off_len[i]);
      end
    end
  endtask : trial

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(17674));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (ta[i]) if (i < 5) rd(8'h0F + 8'(i) + ((i == 4) ? 8'h0D : 8'h00), 8'h00);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'h03);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h7F);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    // Write then read the same register on consecutive edges
    @(posedge clk_sys);
    reg_addr <= 8'h12;
    reg_wdata <= 8'hA5;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("back to back readback", 8'hA5, reg_rdata);
    $display("register test done");
    for (int law = 0; law < 4; law++) begin
      wr(8'h0F, {6'h2A, 2'(law)});
      repeat (2) @(posedge clk_sys);
      #1;
      check("square law", {7'h00, law != 0}, {7'h00, dac_square_law});
      check("step profile", (law < 2) ? 8'h00 : 8'(law - 1), {6'h00, time_step_profile});
    end
    $display("fade law test done");
    for (int t = 0; t < 6; t++) begin
      ta = (t == 0) ? 8'hFF : (t == 1) ? 8'h1B : 8'($urandom);
      tb = (t == 0) ? 8'hFF : (t == 1) ? 8'hE4 : 8'($urandom);
      trial(ta, tb);
    end
    $display("blink test done");
    wr(8'h10, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check("all off", 8'h00, {1'b0, sink_on});
    $display("disable test done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
